// ---- design/iod_pkg.sv ----
package iod_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TEMP      = 8'h0E;
	localparam logic [7:0] IDX_FIELD_X   = 8'h28;
	localparam logic [7:0] IDX_FIELD_Y   = 8'h2A;
	localparam logic [7:0] IDX_FIELD_Z   = 8'h2C;
	localparam logic [7:0] IDX_PRESS_LO  = 8'h2E;
	localparam logic [7:0] IDX_PRESS_HI  = 8'h30;
	localparam logic [7:0] IDX_DVEL_X_LO = 8'h4C;
	localparam logic [7:0] IDX_DVEL_X_HI = 8'h4E;
	localparam logic [7:0] IDX_DVEL_Y_LO = 8'h50;
	localparam logic [7:0] IDX_DVEL_Y_HI = 8'h52;
	localparam logic [7:0] IDX_DVEL_Z_LO = 8'h54;
	localparam logic [7:0] IDX_DVEL_Z_HI = 8'h56;
	localparam logic [7:0] IDX_DEC       = 8'h60;
	localparam logic [7:0] IDX_CLK_SEL   = 8'h61;
	localparam logic [7:0] IDX_STATUS    = 8'h62;

	localparam int APB_ADDR_W = 12;
	localparam int WORD_W     = 16;
	localparam int DEC_W      = 11;
	localparam int PER_W      = 17;
	localparam int DV_W       = 32;
	localparam int NUM_AXES   = 3;

	// Status bit positions
	localparam int ST_DVEL_NEW  = 0;
	localparam int ST_EXT_SLOW  = 1;
	localparam int ST_FIELD_NEW = 2;
	localparam int ST_PRESS_NEW = 3;
	localparam int ST_W         = 4;

	localparam logic [DEC_W-1:0] DEC_RESET     = 11'h000;
	localparam logic             CLK_SEL_RESET = 1'b0;

	// Timing
	localparam int CORE_CLK_HZ   = 100_000_000;
	localparam int INT_FS_SPS    = 2460;
	localparam int EXT_FS_MIN_HZ = 2000;
	localparam logic [PER_W-1:0] INT_PERIOD_CYC =
		PER_W'(CORE_CLK_HZ / INT_FS_SPS);
	localparam logic [PER_W-1:0] EXT_PERIOD_MAX_CYC =
		PER_W'(CORE_CLK_HZ / EXT_FS_MIN_HZ);

	// Scaling: out = sum * period * coef >>> shift, out lsb = 200/2^31 m/s
	localparam real ACCL_LSB_MPS2 = 0.0008 * 9.80665;
	localparam real DV_RANGE_MPS  = 200.0;
	localparam int  DV_SHIFT      = 24;
	localparam int  COEF_W        = 16;
	localparam logic [COEF_W-1:0] DV_COEF = COEF_W'(int'(
		ACCL_LSB_MPS2 * (2.0 ** 31) * (2.0 ** DV_SHIFT)
		/ (2.0 * DV_RANGE_MPS * CORE_CLK_HZ)));

endpackage

// ---- design/iod_dvel_axis.sv ----
`timescale 1ns/100ps
module iod_dvel_axis #(
	parameter int SAMP_W = 16,
	parameter int DEC_W  = 11,
	parameter int PER_W  = 17,
	parameter int OUT_W  = 32
) (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_valid,
	input  wire logic signed [SAMP_W-1:0] i_sample,
	input  wire logic [DEC_W-1:0]         i_dec,
	input  wire logic [PER_W-1:0]         i_period,
	output logic                          o_done,
	output logic [OUT_W-1:0]              o_value
);
	localparam int SUM_W  = SAMP_W + 1 + DEC_W;
	localparam int PROD_W = 64;
	localparam logic signed [PROD_W-1:0] OUT_MAX =
		PROD_W'((64'sd1 <<< (OUT_W - 1)) - 64'sd1);
	localparam logic signed [PROD_W-1:0] OUT_MIN = -OUT_MAX - 64'sd1;

	logic signed [SAMP_W-1:0] prev_q;
	logic signed [SUM_W-1:0]  sum_q;
	logic [DEC_W-1:0]         cnt_q;
	logic [OUT_W-1:0]         value_q;
	logic                     done_q;

	wire logic signed [SUM_W-1:0]  pair_w;
	wire logic signed [SUM_W-1:0]  sum_next_w;
	wire logic                     last_w;
	wire logic signed [PROD_W-1:0] prod_w;
	wire logic signed [PROD_W-1:0] scaled_w;
	wire logic [OUT_W-1:0]         sat_w;

	// Each new sample adds itself and its predecessor
	assign pair_w = SUM_W'(i_sample) + SUM_W'(prev_q);
	assign sum_next_w = sum_q + pair_w;
	assign last_w = (cnt_q >= i_dec);
	assign prod_w = PROD_W'(sum_next_w)
		* $signed({1'b0, i_period})
		* $signed({1'b0, iod_pkg::DV_COEF});
	assign scaled_w = prod_w >>> iod_pkg::DV_SHIFT;
	// Clamp to 32-bit two's complement
	assign sat_w = (scaled_w > OUT_MAX) ? OUT_MAX[OUT_W-1:0] :
		(scaled_w < OUT_MIN) ? OUT_MIN[OUT_W-1:0] :
		scaled_w[OUT_W-1:0];

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prev_q  <= '0;
			sum_q   <= '0;
			cnt_q   <= '0;
			value_q <= '0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (i_valid) begin
				prev_q <= i_sample;
				if (last_w) begin
					sum_q   <= '0;
					cnt_q   <= '0;
					value_q <= sat_w;
					done_q  <= 1'b1;
				end else begin
					sum_q <= sum_next_w;
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end

	assign o_done  = done_q;
	assign o_value = value_q;
endmodule // iod_dvel_axis

// ---- design/iod_output_regs.sv ----
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module iod_output_regs #(
	parameter int DEC_W = iod_pkg::DEC_W,
	parameter int PER_W = iod_pkg::PER_W
) (
	input  wire logic                              i_core_clk,
	input  wire logic                              i_rst,
	// APB slave
	input  wire logic                              i_psel,
	input  wire logic                              i_penable,
	input  wire logic                              i_pwrite,
	input  wire logic [iod_pkg::APB_ADDR_W-1:0]    i_paddr,
	input  wire logic [31:0]                       i_pwdata,
	output logic [31:0]                            o_prdata,
	output logic                                   o_pready,
	output logic                                   o_pslverr,
	// Acceleration samples at the pre-decimation rate
	input  wire logic                              i_accl_valid,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_accl_x,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_accl_y,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_accl_z,
	// Magnetometer samples
	input  wire logic                              i_field_valid,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_field_x,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_field_y,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_field_z,
	// Pressure sample, 32-bit
	input  wire logic                              i_press_valid,
	input  wire logic [2*iod_pkg::WORD_W-1:0]      i_press,
	// Temperature sample
	input  wire logic                              i_temp_valid,
	input  wire logic [iod_pkg::WORD_W-1:0]        i_temp
);
	localparam int W  = iod_pkg::WORD_W;
	localparam int NA = iod_pkg::NUM_AXES;
	localparam int IW = iod_pkg::APB_ADDR_W - 2;

	// Control and sample registers
	logic [DEC_W-1:0]        dec_q;
	logic                    clk_sel_q;
	logic [iod_pkg::ST_W-1:0] status_q;
	logic [iod_pkg::ST_W-1:0] status_d;
	logic [iod_pkg::ST_W-1:0] st_seen_q;
	logic [W-1:0]            field_x_q;
	logic [W-1:0]            field_y_q;
	logic [W-1:0]            field_z_q;
	logic [2*W-1:0]          press_q;
	logic [W-1:0]            temp_q;
	logic [PER_W-1:0]        cyc_q;
	logic [PER_W-1:0]        per_meas_q;
	logic [31:0]             prdata_q;
	logic                    err_q;

	// Delta velocity per axis
	wire logic [W-1:0]              accl_w [NA];
	wire logic [iod_pkg::DV_W-1:0]  dvel_w [NA];
	wire logic [NA-1:0]             dvel_done_w;
	wire logic [PER_W-1:0]          period_w;
	wire logic                      cyc_sat_w;
	wire logic                      ext_slow_w;

	assign accl_w[0] = i_accl_x;
	assign accl_w[1] = i_accl_y;
	assign accl_w[2] = i_accl_z;

	// Internal clock uses fixed rate; external uses measured spacing
	assign period_w = clk_sel_q ? per_meas_q
		: iod_pkg::INT_PERIOD_CYC;

	genvar g;
	generate
		for (g = 0; g < NA; g++) begin : g_axis
			iod_dvel_axis #(
				.SAMP_W (W),
				.DEC_W  (DEC_W),
				.PER_W  (PER_W),
				.OUT_W  (iod_pkg::DV_W)
			) u_axis (
				.i_core_clk (i_core_clk),
				.i_rst      (i_rst),
				.i_valid    (i_accl_valid),
				.i_sample   (accl_w[g]),
				.i_dec      (dec_q),
				.i_period   (period_w),
				.o_done     (dvel_done_w[g]),
				.o_value    (dvel_w[g])
			);
		end
	endgenerate

	// Sample spacing measurement for the external clock option
	assign cyc_sat_w = (cyc_q == {PER_W{1'b1}});
	assign ext_slow_w = clk_sel_q && i_accl_valid
		&& (cyc_q >= iod_pkg::EXT_PERIOD_MAX_CYC);

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cyc_q      <= '0;
			per_meas_q <= iod_pkg::INT_PERIOD_CYC;
		end else if (i_accl_valid) begin
			cyc_q      <= '0;
			per_meas_q <= cyc_sat_w ? cyc_q : cyc_q + 1'b1;
		end else if (!cyc_sat_w) begin
			cyc_q <= cyc_q + 1'b1;
		end
	end

	// Sensor words are stored as delivered, already in output format
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			field_x_q <= '0;
			field_y_q <= '0;
			field_z_q <= '0;
			press_q   <= '0;
			temp_q    <= '0;
		end else begin
			if (i_field_valid) begin
				field_x_q <= i_field_x;
				field_y_q <= i_field_y;
				field_z_q <= i_field_z;
			end
			if (i_press_valid) begin
				press_q <= i_press;
			end
			if (i_temp_valid) begin
				temp_q <= i_temp;
			end
		end
	end

	// APB decode
	wire logic [IW-1:0] idx_w;
	wire logic          setup_w;
	wire logic          access_w;
	wire logic          hit_temp_w;
	wire logic          hit_fx_w;
	wire logic          hit_fy_w;
	wire logic          hit_fz_w;
	wire logic          hit_plo_w;
	wire logic          hit_phi_w;
	wire logic          hit_vxl_w;
	wire logic          hit_vxh_w;
	wire logic          hit_vyl_w;
	wire logic          hit_vyh_w;
	wire logic          hit_vzl_w;
	wire logic          hit_vzh_w;
	wire logic          hit_dec_w;
	wire logic          hit_clk_w;
	wire logic          hit_st_w;
	wire logic          hit_ro_w;
	wire logic          hit_rw_w;
	wire logic          bad_w;
	wire logic [31:0]   rd_w;

	assign idx_w    = i_paddr[iod_pkg::APB_ADDR_W-1:2];
	assign setup_w  = i_psel && !i_penable;
	assign access_w = i_psel && i_penable;

	assign hit_temp_w = (idx_w == IW'(iod_pkg::IDX_TEMP));
	assign hit_fx_w   = (idx_w == IW'(iod_pkg::IDX_FIELD_X));
	assign hit_fy_w   = (idx_w == IW'(iod_pkg::IDX_FIELD_Y));
	assign hit_fz_w   = (idx_w == IW'(iod_pkg::IDX_FIELD_Z));
	assign hit_plo_w  = (idx_w == IW'(iod_pkg::IDX_PRESS_LO));
	assign hit_phi_w  = (idx_w == IW'(iod_pkg::IDX_PRESS_HI));
	assign hit_vxl_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_X_LO));
	assign hit_vxh_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_X_HI));
	assign hit_vyl_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_Y_LO));
	assign hit_vyh_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_Y_HI));
	assign hit_vzl_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_Z_LO));
	assign hit_vzh_w  = (idx_w == IW'(iod_pkg::IDX_DVEL_Z_HI));
	assign hit_dec_w  = (idx_w == IW'(iod_pkg::IDX_DEC));
	assign hit_clk_w  = (idx_w == IW'(iod_pkg::IDX_CLK_SEL));
	assign hit_st_w   = (idx_w == IW'(iod_pkg::IDX_STATUS));

	assign hit_ro_w = hit_temp_w | hit_fx_w | hit_fy_w | hit_fz_w
		| hit_plo_w | hit_phi_w | hit_vxl_w | hit_vxh_w
		| hit_vyl_w | hit_vyh_w | hit_vzl_w | hit_vzh_w | hit_st_w;
	assign hit_rw_w = hit_dec_w | hit_clk_w;
	// Unmapped address or write to a read-only word
	assign bad_w = !(hit_ro_w | hit_rw_w) || (i_pwrite && hit_ro_w);

	// Low and high halves come from one stored word
	assign rd_w =
		hit_temp_w ? {16'h0000, temp_q} :
		hit_fx_w   ? {16'h0000, field_x_q} :
		hit_fy_w   ? {16'h0000, field_y_q} :
		hit_fz_w   ? {16'h0000, field_z_q} :
		hit_plo_w  ? {16'h0000, press_q[W-1:0]} :
		hit_phi_w  ? {16'h0000, press_q[2*W-1:W]} :
		hit_vxl_w  ? {16'h0000, dvel_w[0][W-1:0]} :
		hit_vxh_w  ? {16'h0000, dvel_w[0][2*W-1:W]} :
		hit_vyl_w  ? {16'h0000, dvel_w[1][W-1:0]} :
		hit_vyh_w  ? {16'h0000, dvel_w[1][2*W-1:W]} :
		hit_vzl_w  ? {16'h0000, dvel_w[2][W-1:0]} :
		hit_vzh_w  ? {16'h0000, dvel_w[2][2*W-1:W]} :
		hit_dec_w  ? {{(32-DEC_W){1'b0}}, dec_q} :
		hit_clk_w  ? {31'h00000000, clk_sel_q} :
		hit_st_w   ? {{(32-iod_pkg::ST_W){1'b0}}, status_q} :
		32'h00000000;

	// Read data and error are captured in the setup cycle
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prdata_q  <= '0;
			err_q     <= 1'b0;
			st_seen_q <= '0;
		end else if (setup_w) begin
			prdata_q  <= i_pwrite ? 32'h00000000 : rd_w;
			err_q     <= bad_w;
			st_seen_q <= (hit_st_w && !i_pwrite) ? status_q : '0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			dec_q     <= DEC_W'(iod_pkg::DEC_RESET);
			clk_sel_q <= iod_pkg::CLK_SEL_RESET;
		end else if (access_w && i_pwrite && !err_q) begin
			if (hit_dec_w) begin
				dec_q <= i_pwdata[DEC_W-1:0];
			end
			if (hit_clk_w) begin
				clk_sel_q <= i_pwdata[0];
			end
		end
	end

	// Status read clears only reported bits; new events win
	always_comb begin
		status_d = status_q;
		if (access_w && !i_pwrite && hit_st_w) begin
			status_d = status_q & ~st_seen_q;
		end
		if (dvel_done_w[0]) begin
			status_d[iod_pkg::ST_DVEL_NEW] = 1'b1;
		end
		if (ext_slow_w) begin
			status_d[iod_pkg::ST_EXT_SLOW] = 1'b1;
		end
		if (i_field_valid) begin
			status_d[iod_pkg::ST_FIELD_NEW] = 1'b1;
		end
		if (i_press_valid) begin
			status_d[iod_pkg::ST_PRESS_NEW] = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	assign o_prdata  = prdata_q;
	assign o_pready  = access_w;
	assign o_pslverr = access_w && err_q;
endmodule // iod_output_regs

// ---- testbench/iod_output_regs_asserts.sv ----
`timescale 1ns/100ps
module iod_output_regs_asserts (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_field_valid,
	input wire logic [15:0] i_field_x,
	input wire logic        i_press_valid,
	input wire logic [31:0] i_press,
	input wire logic        i_temp_valid,
	input wire logic [15:0] i_temp
);
	logic [9:0]  idx;
	logic        mapped;
	logic        wr_ok;
	logic [15:0] temp_q;
	logic [15:0] fx_q;
	logic [31:0] press_q;
	assign idx = i_paddr[11:2];
	assign wr_ok = idx inside {iod_pkg::IDX_DEC, iod_pkg::IDX_CLK_SEL};
	assign mapped = wr_ok || idx inside {iod_pkg::IDX_TEMP,
		iod_pkg::IDX_FIELD_X, iod_pkg::IDX_FIELD_Y, iod_pkg::IDX_FIELD_Z,
		iod_pkg::IDX_PRESS_LO, iod_pkg::IDX_PRESS_HI, iod_pkg::IDX_STATUS,
		iod_pkg::IDX_DVEL_X_LO, iod_pkg::IDX_DVEL_X_HI,
		iod_pkg::IDX_DVEL_Y_LO, iod_pkg::IDX_DVEL_Y_HI,
		iod_pkg::IDX_DVEL_Z_LO, iod_pkg::IDX_DVEL_Z_HI};
	// Shadow of the last sample taken by the block
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			temp_q  <= 16'h0000;
			fx_q    <= 16'h0000;
			press_q <= 32'h0000_0000;
		end else begin
			if (i_temp_valid) temp_q <= i_temp;
			if (i_field_valid) fx_q <= i_field_x;
			if (i_press_valid) press_q <= i_press;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	sequence setup_s(logic w);
		i_psel && !i_penable && (i_pwrite == w);
	endsequence
	sequence rd_s(logic [7:0] r);
		setup_s(1'b0) ##0 (idx == 10'(r));
	endsequence
	pready_a: assert property (o_pready == (i_psel && i_penable))
		else $error("pready not tied to access phase");
	err_idle_a: assert property (!o_pready |-> !o_pslverr)
		else $error("pslverr outside access");
	bad_addr_a: assert property (i_psel && !i_penable && !mapped |=> o_pslverr)
		else $error("unmapped access not refused");
	ro_write_a: assert property (setup_s(1'b1) ##0 !wr_ok |=> o_pslverr)
		else $error("read-only write not refused");
	good_read_a: assert property (setup_s(1'b0) ##0 mapped |=> !o_pslverr)
		else $error("mapped read refused");
	wr_zero_a: assert property (o_pready && i_pwrite |-> o_prdata == 32'h0)
		else $error("read data not zero on write");
	upper_zero_a: assert property (o_pready |-> o_prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	temp_rd_a: assert property (rd_s(iod_pkg::IDX_TEMP)
		|=> o_prdata[15:0] == $past(temp_q)) else $error("temperature read");
	field_rd_a: assert property (rd_s(iod_pkg::IDX_FIELD_X)
		|=> o_prdata[15:0] == $past(fx_q)) else $error("field read");
	press_hi_a: assert property (rd_s(iod_pkg::IDX_PRESS_HI)
		|=> o_prdata[15:0] == $past(press_q[31:16])) else $error("press hi");
	press_lo_a: assert property (rd_s(iod_pkg::IDX_PRESS_LO)
		|=> o_prdata[15:0] == $past(press_q[15:0])) else $error("press lo");
endmodule // iod_output_regs_asserts
bind iod_output_regs iod_output_regs_asserts i_chk (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.i_field_valid(i_field_valid), .i_field_x(i_field_x),
	.i_press_valid(i_press_valid), .i_press(i_press),
	.i_temp_valid(i_temp_valid), .i_temp(i_temp));

// ---- testbench/iod_host_model.sv ----
`timescale 1ns/100ps
module iod_host_model (
	input  wire logic        i_core_clk,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [11:0]      o_paddr,
	output logic [31:0]      o_pwdata
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0;
	end
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge i_core_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_core_clk);
		o_penable <= 1'b1;
		do begin
			@(posedge i_core_clk);
		end while (i_pready !== 1'b1);
		q = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// Idle bus shows junk, not the last values
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask
endmodule // iod_host_model

// ---- testbench/iod_output_regs_tb_top.sv ----
`timescale 1ns/100ps
module iod_output_regs_tb_top;
	localparam logic [7:0] DLO [3] = '{iod_pkg::IDX_DVEL_X_LO,
		iod_pkg::IDX_DVEL_Y_LO, iod_pkg::IDX_DVEL_Z_LO};
	localparam logic [7:0] DHI [3] = '{iod_pkg::IDX_DVEL_X_HI,
		iod_pkg::IDX_DVEL_Y_HI, iod_pkg::IDX_DVEL_Z_HI};
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, pr;
	logic        av, fv, pv, tv;
	logic [15:0] ax, ay, az, fx, fy, fz, tp;
	logic [31:0] ex [3];
	longint      prv [3], sum [3], per;
	int          failures, check_count, seed, cnt, dec, cyc = 0;
	iod_output_regs i_dut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_accl_valid(av), .i_accl_x(ax),
		.i_accl_y(ay), .i_accl_z(az), .i_field_valid(fv), .i_field_x(fx),
		.i_field_y(fy), .i_field_z(fz), .i_press_valid(pv), .i_press(pr),
		.i_temp_valid(tv), .i_temp(tp));
	iod_host_model i_host (.i_core_clk(clk), .i_prdata(prdata),
		.i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			finish_test;
		end
	end
	task automatic chk(input string n, input logic [31:0] s, x);
		check_count++;
		if (s !== x) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		i_host.xfer(1'b1, 12'(i) << 2, d, q, e);
	endtask
	task automatic rc(input string n, input logic [7:0] i,
		input logic [31:0] x, input logic xe);
		i_host.xfer(1'b0, 12'(i) << 2, 32'h0, q, e);
		chk(n, q, x);
		chk({n, " err"}, {31'h0, e}, {31'h0, xe});
	endtask
	function automatic logic [31:0] dvx(input longint s);
		longint v;
		v = (s * per * longint'(iod_pkg::DV_COEF)) >>> 24;
		return v[31:0];
	endfunction
	task automatic accl(input int gap);
		logic [15:0] a [3];
		real         rv, df, tl;
		logic        ok;
		for (int k = 0; k < 3; k++) a[k] = 16'($random(seed));
		@(posedge clk);
		av <= 1'b1;
		ax <= a[0];
		ay <= a[1];
		az <= a[2];
		@(posedge clk);
		av <= 1'b0;
		ax <= ~a[0];
		repeat (gap - 2) @(posedge clk);
		for (int k = 0; k < 3; k++) begin
			sum[k] += longint'($signed(a[k])) + prv[k];
			prv[k] = longint'($signed(a[k]));
		end
		cnt++;
		if (cnt == dec + 1) begin
			for (int k = 0; k < 3; k++) ex[k] = dvx(sum[k]);
			// Integer model against the real-valued integral
			for (int k = 0; k < 3; k++) begin
				rv = real'(sum[k]) * iod_pkg::ACCL_LSB_MPS2 * real'(per)
					/ (2.0 * iod_pkg::CORE_CLK_HZ) * (2.0 ** 31) / 200.0;
				df = real'($signed(ex[k])) - rv;
				tl = 2.0 + ((rv < 0.0) ? -rv : rv) / 1000.0;
				ok = (df <= tl) && (df >= -tl);
				chk("dv scale", {31'h0, ok}, 32'h1);
			end
			for (int k = 0; k < 3; k++) sum[k] = 0;
			cnt = 0;
		end
	endtask
	task automatic dv_read;
		for (int k = 0; k < 3; k++) begin
			rc("dv lo", DLO[k], {16'h0, ex[k][15:0]}, 1'b0);
			rc("dv hi", DHI[k], {16'h0, ex[k][31:16]}, 1'b0);
		end
	endtask
	initial begin
		seed = 54240;
		failures = 0;
		check_count = 0;
		{rst, av, fv, pv, tv} = 5'h1F;
		{av, fv, pv, tv} = 4'h0;
		{ax, ay, az, fx, fy, fz, tp, pr} = '0;
		for (int k = 0; k < 3; k++) {prv[k], sum[k]} = '0;
		{cnt, dec} = '0;
		per = longint'(iod_pkg::INT_PERIOD_CYC);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc("temp rst", iod_pkg::IDX_TEMP, 32'h0, 1'b0);
		rc("unmapped", 8'h01, 32'h0, 1'b1);
		wr(iod_pkg::IDX_TEMP, 32'h0000_1234);
		chk("ro write err", {31'h0, e}, 32'h1);
		@(posedge clk);
		{fv, pv, tv} <= 3'h7;
		fx <= 16'($random(seed));
		fy <= 16'h8000;
		fz <= 16'h7FFF;
		pr <= 32'($random(seed));
		tp <= 16'($random(seed));
		@(posedge clk);
		{fv, pv, tv} <= 3'h0;
		rc("fx", iod_pkg::IDX_FIELD_X, {16'h0, fx}, 1'b0);
		rc("fy", iod_pkg::IDX_FIELD_Y, {16'h0, fy}, 1'b0);
		rc("fz", iod_pkg::IDX_FIELD_Z, {16'h0, fz}, 1'b0);
		rc("p lo", iod_pkg::IDX_PRESS_LO, {16'h0, pr[15:0]}, 1'b0);
		rc("p hi", iod_pkg::IDX_PRESS_HI, {16'h0, pr[31:16]}, 1'b0);
		rc("temp", iod_pkg::IDX_TEMP, {16'h0, tp}, 1'b0);
		foreach (DLO[d]) begin
			dec = d * 3;
			wr(iod_pkg::IDX_DEC, 32'(dec));
			rc("dec", iod_pkg::IDX_DEC, 32'(dec), 1'b0);
			repeat (dec + 1) accl(4);
			dv_read;
			if (d == 1) break;
		end
		wr(iod_pkg::IDX_CLK_SEL, 32'h1);
		per = 1000;
		repeat (dec + 1) accl(1000);
		dv_read;
		rc("status", iod_pkg::IDX_STATUS, 32'((1 << iod_pkg::ST_DVEL_NEW)
			| (1 << iod_pkg::ST_FIELD_NEW) | (1 << iod_pkg::ST_PRESS_NEW)),
			1'b0);
		rc("status clr", iod_pkg::IDX_STATUS, 32'h0, 1'b0);
		finish_test;
	end
endmodule // iod_output_regs_tb_top
